// File: asu_map.svh
// Register offsets, field positions and reset values of the UART core.
// Assumes byte addressing on a 32-bit APB bus, one word per register.
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH

// Register byte addresses
`define ASU_ADDR_DATA 8'h00
`define ASU_ADDR_STAT 8'h04
`define ASU_ADDR_CTL0 8'h08
`define ASU_ADDR_CTL1 8'h0c
`define ASU_ADDR_DIV 8'h10

// Control 0 fields
`define ASU_C0_TXEN 0
`define ASU_C0_RXEN 1
`define ASU_C0_GATE 2
`define ASU_C0_PAR 3
`define ASU_C0_ODD 4
`define ASU_C0_BRK 5
`define ASU_C0_STOP2 6
`define ASU_C0_LOOP 7

// Control 1 fields
`define ASU_C1_RDI_DIS 0
`define ASU_C1_MP_ON 1
`define ASU_C1_MP_ALLADR 2
`define ASU_C1_MP_TXBIT 3
`define ASU_C1_ADR_LSB 8

// Status fields
`define ASU_S_AVAIL 0
`define ASU_S_THRE 1
`define ASU_S_OVR 2
`define ASU_S_BRK 3
`define ASU_S_FE 4
`define ASU_S_PE 5
`define ASU_S_TXIDLE 6
`define ASU_S_CTS 7
`define ASU_S_ADR 8
`define ASU_S_TXGO 9

// Reset values and minimum divisor
`define ASU_CTL0_RST 8'h00
`define ASU_CTL1_RST 16'h0000
`define ASU_DIV_RST 16'h043d
`define ASU_DIV_MIN 16'h0002

// Frame layout
`define ASU_TXF_W 12
`define ASU_RXF_W 11
`define ASU_BITS_8 4'h8
`define ASU_BITS_9 4'h9

`endif

// File: asu_pkg.sv
// Types shared by the UART core.
// Assumes asu_map.svh supplies the numeric constants.
package asu_pkg;

   typedef enum logic [0:0] {
      TX_IDLE,
      TX_SHIFT
   } asu_tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_BITS,
      RX_WAIT_HIGH
   } asu_rx_state_t;

endpackage

// File: asu_uart_core.sv
// Asynchronous serial transmitter and receiver with an APB register file.
// Assumes one clock pclk, async low reset, rxd and cts_n from pins.
//
// Behaviour
// - Eight data bits, least significant first
// - Low start bit, stop bits high
// - Holding-empty set at load, giving reload time
// - Writing transmit data clears holding-empty
// - Receive interrupt: data, break, overrun, framing
// - Data interrupt separately disabled, after load
// - Multiprocessor mode gates data interrupts
// - Overrun keeps the held valid byte
// - Overrun and break hidden until read
// - After read show overrun, keep available
// - Break flag shows break caused overrun
// - Second data read clears error flags
// - Data register changes only on character
// - Gate on: start transmit only while cts low
// - Gate off: cts ignored
// - Receive enable turns receiver on/off
// - Parity enable adds/expects parity bit
// - Parity select: 0 even, 1 odd
// - Send break forces line low, aborts
// - Stop select: one or two stops
// - Loopback routes transmitter into receiver
`timescale 1ns/100ps
`include "asu_map.svh"

module asu_uart_core (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic rxd,
   input wire logic cts_n,
   output logic txd,
   // Receive interrupt request
   output logic rx_irq
);
   import asu_pkg::*;

   function automatic logic par_bit(input logic [7:0] d,
                                    input logic odd);
      par_bit = (^d) ^ odd;
   endfunction

   function automatic logic [15:0] bit_cyc(input logic [15:0] d);
      bit_cyc = (d < `ASU_DIV_MIN) ? `ASU_DIV_MIN : d;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `ASU_ADDR_DATA) || (a == `ASU_ADDR_STAT) ||
               (a == `ASU_ADDR_CTL0) || (a == `ASU_ADDR_CTL1) ||
               (a == `ASU_ADDR_DIV);
   endfunction

   logic rxd_s1_ff, rxd_s2_ff, cts_s1_ff, cts_s2_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;
   logic [7:0] ctl0_ff;
   logic [15:0] ctl1_ff, div_ff;
   logic [7:0] tx_hold_ff;
   logic tx_holding_empty_flag;
   asu_tx_state_t tx_state_ff;
   logic [`ASU_TXF_W-1:0] tx_sh_ff;
   logic [3:0] tx_left_ff;
   logic [15:0] tx_cnt_ff;
   logic tx_line_ff, txd_ff;
   asu_rx_state_t rx_state_ff;
   logic [`ASU_RXF_W-1:0] rx_sh_ff;
   logic [3:0] rx_left_ff;
   logic [15:0] rx_cnt_ff;
   logic rx_done_ff;
   logic [7:0] rx_data_ff;
   logic rx_byte_available_flag, line_break_seen_flag;
   logic ovr_shown_ff, ovr_pend_ff, brk_pend_ff;
   logic fe_ff, pe_ff, adr_ff, mp_sel_ff, rx_irq_ff;
   logic [31:0] rd_mux;

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_s1_ff <= 1'b1;
         rxd_s2_ff <= 1'b1;
         cts_s1_ff <= 1'b1;
         cts_s2_ff <= 1'b1;
      end else begin
         rxd_s1_ff <= rxd;
         rxd_s2_ff <= rxd_s1_ff;
         cts_s1_ff <= cts_n;
         cts_s2_ff <= cts_s1_ff;
      end
   end

   wire logic acc = psel & penable & pready_ff;
   wire logic wr = acc & pwrite;
   wire logic rd_rx = acc & ~pwrite & (paddr == `ASU_ADDR_DATA);
   wire logic wr_tx = wr & (paddr == `ASU_ADDR_DATA);

   wire logic tx_en = ctl0_ff[`ASU_C0_TXEN];
   wire logic gate = ctl0_ff[`ASU_C0_GATE];
   wire logic brk_on = ctl0_ff[`ASU_C0_BRK];
   wire logic loop = ctl0_ff[`ASU_C0_LOOP];
   wire logic odd = ctl0_ff[`ASU_C0_ODD];
   wire logic mp_on = ctl1_ff[`ASU_C1_MP_ON];
   wire logic [7:0] mp_adr = ctl1_ff[`ASU_C1_ADR_LSB +: 8];
   // Ninth bit carries parity or the address flag
   wire logic nine = ctl0_ff[`ASU_C0_PAR] | mp_on;
   wire logic [15:0] bit_len = bit_cyc(div_ff) - 16'h0001;
   wire logic tx_go = tx_en & (~gate | ~cts_s2_ff);
   wire logic tx_load = (tx_state_ff == TX_IDLE) & ~brk_on &
                        ~tx_holding_empty_flag & tx_go;
   wire logic tx_ninth = mp_on ? ctl1_ff[`ASU_C1_MP_TXBIT] :
                         par_bit(tx_hold_ff, odd);

   // APB read mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `ASU_ADDR_DATA: rd_mux[7:0] = rx_data_ff;
         `ASU_ADDR_STAT: begin
            rd_mux[`ASU_S_AVAIL] = rx_byte_available_flag;
            rd_mux[`ASU_S_THRE] = tx_holding_empty_flag;
            rd_mux[`ASU_S_OVR] = ovr_shown_ff;
            rd_mux[`ASU_S_BRK] = line_break_seen_flag;
            rd_mux[`ASU_S_FE] = fe_ff;
            rd_mux[`ASU_S_PE] = pe_ff;
            rd_mux[`ASU_S_TXIDLE] = tx_holding_empty_flag &
                                   (tx_state_ff == TX_IDLE);
            rd_mux[`ASU_S_CTS] = cts_s2_ff;
            rd_mux[`ASU_S_ADR] = adr_ff;
            rd_mux[`ASU_S_TXGO] = tx_go;
         end
         `ASU_ADDR_CTL0: rd_mux[7:0] = ctl0_ff;
         `ASU_ADDR_CTL1: rd_mux[15:0] = ctl1_ff;
         `ASU_ADDR_DIV: rd_mux[15:0] = div_ff;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // APB handshake: no wait state, data caught in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~mapped(paddr);
         if (psel & ~penable & ~pwrite) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0_ff <= `ASU_CTL0_RST;
         ctl1_ff <= `ASU_CTL1_RST;
         div_ff <= `ASU_DIV_RST;
      end else if (wr) begin
         case (paddr)
            `ASU_ADDR_CTL0: ctl0_ff <= pwdata[7:0];
            `ASU_ADDR_CTL1: ctl1_ff <= pwdata[15:0];
            `ASU_ADDR_DIV: div_ff <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Transmit holding register and its empty flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_hold_ff <= 8'h00;
         tx_holding_empty_flag <= 1'b1;
      end else if (wr_tx) begin
         tx_hold_ff <= pwdata[7:0];
         tx_holding_empty_flag <= 1'b0;
      end else if (tx_load) begin
         tx_holding_empty_flag <= 1'b1;
      end
   end

   // Transmit shifter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_ff <= TX_IDLE;
         tx_sh_ff <= '1;
         tx_left_ff <= 4'h0;
         tx_cnt_ff <= 16'h0000;
         tx_line_ff <= 1'b1;
      end else begin
         case (tx_state_ff)
            TX_IDLE: begin
               tx_line_ff <= ~brk_on;
               if (tx_load) begin
                  tx_state_ff <= TX_SHIFT;
                  tx_line_ff <= 1'b0;
                  // Start already on line; rest shifts LSB first
                  if (nine) begin
                     tx_sh_ff <= {3'b111, tx_ninth, tx_hold_ff};
                  end else begin
                     tx_sh_ff <= {4'b1111, tx_hold_ff};
                  end
                  tx_left_ff <= (nine ? `ASU_BITS_9 : `ASU_BITS_8) +
                     (ctl0_ff[`ASU_C0_STOP2] ? 4'h2 : 4'h1);
                  tx_cnt_ff <= bit_len;
               end
            end
            TX_SHIFT: begin
               if (brk_on) begin
                  tx_state_ff <= TX_IDLE;
                  tx_line_ff <= 1'b0;
               end else if (tx_cnt_ff == 16'h0000) begin
                  tx_cnt_ff <= bit_len;
                  if (tx_left_ff == 4'h0) begin
                     tx_state_ff <= TX_IDLE;
                     tx_line_ff <= 1'b1;
                  end else begin
                     tx_line_ff <= tx_sh_ff[0];
                     tx_sh_ff <= {1'b1, tx_sh_ff[`ASU_TXF_W-1:1]};
                     tx_left_ff <= tx_left_ff - 4'h1;
                  end
               end else begin
                  tx_cnt_ff <= tx_cnt_ff - 16'h0001;
               end
            end
            default: tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   // Pin idles high while looped back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd_ff <= 1'b1;
      end else begin
         txd_ff <= loop ? 1'b1 : tx_line_ff;
      end
   end

   wire logic rx_in = loop ? tx_line_ff : rxd_s2_ff;
   wire logic rx_en = ctl0_ff[`ASU_C0_RXEN];

   // Receive sampler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_ff <= RX_IDLE;
         rx_sh_ff <= '0;
         rx_left_ff <= 4'h0;
         rx_cnt_ff <= 16'h0000;
         rx_done_ff <= 1'b0;
      end else begin
         rx_done_ff <= 1'b0;
         if (!rx_en) begin
            rx_state_ff <= RX_IDLE;
         end else begin
            case (rx_state_ff)
               RX_IDLE: begin
                  if (!rx_in) begin
                     rx_state_ff <= RX_START;
                     rx_cnt_ff <= bit_cyc(div_ff) >> 1;
                  end
               end
               RX_START: begin
                  if (rx_cnt_ff != 16'h0000) begin
                     rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                  end else if (rx_in) begin
                     rx_state_ff <= RX_IDLE;
                  end else begin
                     rx_state_ff <= RX_BITS;
                     rx_cnt_ff <= bit_len;
                     rx_sh_ff <= '0;
                     rx_left_ff <= nine ? `ASU_BITS_9 : `ASU_BITS_8;
                  end
               end
               RX_BITS: begin
                  if (rx_cnt_ff != 16'h0000) begin
                     rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                  end else begin
                     rx_cnt_ff <= bit_len;
                     rx_sh_ff <= {rx_in, rx_sh_ff[`ASU_RXF_W-1:1]};
                     rx_left_ff <= rx_left_ff - 4'h1;
                     if (rx_left_ff == 4'h0) begin
                        rx_done_ff <= 1'b1;
                        rx_state_ff <= rx_in ? RX_IDLE : RX_WAIT_HIGH;
                     end
                  end
               end
               RX_WAIT_HIGH: begin
                  if (rx_in) begin
                     rx_state_ff <= RX_IDLE;
                  end
               end
               default: rx_state_ff <= RX_IDLE;
            endcase
         end
      end
   end

   // Decode of the finished character
   wire logic [7:0] rx_byte = nine ? rx_sh_ff[8:1] : rx_sh_ff[9:2];
   wire logic rx_ninth = rx_sh_ff[9];
   wire logic rx_fe = ~rx_sh_ff[10];
   wire logic rx_brk = ~|rx_sh_ff;
   wire logic rx_pe = ctl0_ff[`ASU_C0_PAR] & ~mp_on &
                      (rx_ninth != par_bit(rx_byte, odd));
   wire logic rx_adr = mp_on & rx_ninth;
   // Data register free if empty, or read without pending overrun
   wire logic rx_free = ~rx_byte_available_flag |
                        (rd_rx & ~ovr_pend_ff);

   // Receive data and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_ff <= 8'h00;
         rx_byte_available_flag <= 1'b0;
         line_break_seen_flag <= 1'b0;
         ovr_shown_ff <= 1'b0;
         ovr_pend_ff <= 1'b0;
         brk_pend_ff <= 1'b0;
         fe_ff <= 1'b0;
         pe_ff <= 1'b0;
         adr_ff <= 1'b0;
         mp_sel_ff <= 1'b0;
      end else begin
         if (rd_rx) begin
            if (ovr_pend_ff) begin
               ovr_pend_ff <= 1'b0;
               ovr_shown_ff <= 1'b1;
               line_break_seen_flag <= brk_pend_ff;
               brk_pend_ff <= 1'b0;
            end else begin
               rx_byte_available_flag <= 1'b0;
               ovr_shown_ff <= 1'b0;
               line_break_seen_flag <= 1'b0;
               fe_ff <= 1'b0;
               pe_ff <= 1'b0;
            end
         end
         if (rx_done_ff) begin
            if (rx_free) begin
               rx_data_ff <= rx_byte;
               rx_byte_available_flag <= 1'b1;
               line_break_seen_flag <= rx_brk;
               fe_ff <= rx_fe;
               pe_ff <= rx_pe;
               adr_ff <= rx_ninth & mp_on;
               if (rx_adr) begin
                  mp_sel_ff <= (rx_byte == mp_adr);
               end
            end else begin
               ovr_pend_ff <= 1'b1;
               // A read that just showed the old break starts afresh
               brk_pend_ff <= rx_brk | (brk_pend_ff &
                              ~(rd_rx & ovr_pend_ff));
            end
         end
      end
   end

   // Data interrupt qualified by multiprocessor state
   wire logic mp_ok = ~mp_on | mp_sel_ff |
                      (adr_ff & ctl1_ff[`ASU_C1_MP_ALLADR]);
   wire logic data_req = rx_byte_available_flag & mp_ok &
                         ~ctl1_ff[`ASU_C1_RDI_DIS];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_irq_ff <= 1'b0;
      end else begin
         rx_irq_ff <= data_req | ovr_shown_ff | line_break_seen_flag |
                      fe_ff;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign txd = txd_ff;
   assign rx_irq = rx_irq_ff;

endmodule // asu_uart_core

// File: asu_uart_core_sva.sv
// Port checker for the UART core, bound to every instance.
// Assumes one APB master and one word per register.
`timescale 1ns/100ps
`include "asu_map.svh"
module asu_uart_core_sva (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Serial
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic txd,
   input wire logic rx_irq
);
   logic [7:0] ctl0_ff;
   logic brk;
   logic lpb;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Shadow of control 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0_ff <= `ASU_CTL0_RST;
      end else if (psel && penable && pready && pwrite &&
                   paddr == `ASU_ADDR_CTL0) begin
         ctl0_ff <= pwdata[7:0];
      end
   end
   assign brk = ctl0_ff[`ASU_C0_BRK] && !ctl0_ff[`ASU_C0_LOOP];
   assign lpb = ctl0_ff[`ASU_C0_LOOP];
   chk_ready_once: assert property (pready |=> !pready)
      else $error("pready too long");
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready late");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 0)
      else $error("refused read not zero");
   chk_upper_zero: assert property (pready |-> prdata[31:16] == 0)
      else $error("upper read bits set");
   chk_data_hold: assert property
      (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("prdata moved");
   chk_break_low: assert property (brk && $past(brk, 3) |-> !txd)
      else $error("txd high in break");
   chk_loop_high: assert property (lpb && $past(lpb, 3) |-> txd)
      else $error("txd low in loopback");
   cov_error: cover property (pslverr);
   cov_break: cover property (brk && !txd);
   cov_irq: cover property ($rose(rx_irq));
endmodule // asu_uart_core_sva

bind asu_uart_core asu_uart_core_sva i_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd),
   .rx_irq(rx_irq));

// File: asu_remote_dev.sv
// Remote serial device: frames onto rxd, decodes frames from txd.
// Assumes per matches the core bit period; the bench sets nine_on and stop2 to match the core.
`timescale 1ns/100ps
module asu_remote_dev (
   // Clock
   input wire logic pclk,
   // Serial lines
   output logic rxd,
   input wire logic txd
);
   int per = 4;
   bit nine_on = 1'b0;
   bit stop2 = 1'b0;
   logic [10:0] got[$];
   logic [10:0] fr;
   initial rxd = 1'b1;
   // Start low, data lsb first, ninth bit, stop level s
   task automatic send(input logic [8:0] d, input logic s);
      logic [11:0] f;
      f = nine_on ? {s, s, d, 1'b0} : {s, s, s, d[7:0], 1'b0};
      for (int i = 0; i < 10 + nine_on + stop2; i++) begin
         rxd <= f[i];
         repeat (per) @(posedge pclk);
      end
      rxd <= 1'b1;
      @(posedge pclk);
   endtask
   // Mid-bit sampling after the start edge
   always begin
      @(negedge txd);
      fr = '0;
      repeat (per / 2) @(posedge pclk);
      for (int i = 0; i < 9 + nine_on + stop2; i++) begin
         repeat (per) @(posedge pclk);
         fr[i] = txd;
      end
      got.push_back(fr);
   end
endmodule // asu_remote_dev

// File: test_async_serial_uart_core.sv
// Self-checking bench for the UART core and a remote serial device.
// Assumes the checker binds itself; bit period is set to 4 cycles.
`timescale 1ns/100ps
`include "asu_map.svh"
module test_async_serial_uart_core;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic cts_n, rxd, txd, rx_irq;
   logic [7:0] paddr, b;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] q[$];
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   asu_uart_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
      .cts_n(cts_n), .txd(txd), .rx_irq(rx_irq));
   asu_remote_dev i_rem (.pclk(pclk), .rxd(rxd), .txd(txd));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (num_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_irq(input logic e, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (e && rx_irq === 1'b1) break;
      end
      chk("rx_irq", rx_irq, e);
   endtask
   function automatic logic par(input logic [7:0] d, input logic odd);
      return ^d ^ odd;
   endfunction
   function automatic logic [10:0] exp_frame(input logic [7:0] d,
                                             input int m);
      if (m[0]) return {m[2], 1'b1, par(d, m[1]), d};
      return {1'b0, m[2], 1'b1, d};
   endfunction
   initial begin
      void'($urandom(12192));
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      cts_n = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `ASU_ADDR_CTL0, 32'h0);
      chk("ctl0", rd, `ASU_CTL0_RST);
      apb(0, `ASU_ADDR_CTL1, 32'h0);
      chk("ctl1", rd, `ASU_CTL1_RST);
      apb(0, `ASU_ADDR_DIV, 32'h0);
      chk("div", rd, `ASU_DIV_RST);
      apb(0, 8'h14, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      apb(1, `ASU_ADDR_DIV, 32'h4);
      // Every parity and stop mode, both directions; gate off
      for (int m = 0; m < 8; m++) begin
         i_rem.nine_on = m[0];
         i_rem.stop2 = m[2];
         apb(1, `ASU_ADDR_CTL0, {25'h0, m[2], 1'b0, m[1:0], 3'h3});
         for (int k = 0; k < 2; k++) begin
            b = $urandom;
            q.push_back(b);
            apb(1, `ASU_ADDR_DATA, {24'h0, b});
         end
         apb(0, `ASU_ADDR_STAT, 32'h0);
         chk("thre", rd[`ASU_S_THRE], 0);
         for (int i = 0; i < 200 && i_rem.got.size() < 2; i++) begin
            @(posedge pclk);
         end
         while (q.size() > 0) begin
            b = q.pop_front();
            chk("frame", i_rem.got.pop_front(), exp_frame(b, m));
         end
         b = $urandom;
         i_rem.send({par(b, m[1]), b}, 1'b1);
         wait_irq(1, 60);
         apb(0, `ASU_ADDR_STAT, 32'h0);
         chk("stat", rd[5:0], 6'h03);
         apb(0, `ASU_ADDR_DATA, 32'h0);
         chk("rx", rd, {24'h0, b});
      end
      // Overrun, second char plain then break; never read in time
      i_rem.nine_on = 0;
      i_rem.stop2 = 0;
      apb(1, `ASU_ADDR_CTL0, 32'h3);
      for (int k = 0; k < 2; k++) begin
         b = $urandom;
         i_rem.send({1'b0, b}, 1'b1);
         i_rem.send(k ? 9'h000 : {1'b0, ~b}, k == 0);
         repeat (8) @(posedge pclk);
         apb(0, `ASU_ADDR_STAT, 32'h0);
         chk("hidden", {rd[3:2], rd[0]}, 3'h1);
         apb(0, `ASU_ADDR_DATA, 32'h0);
         chk("kept", rd, {24'h0, b});
         apb(0, `ASU_ADDR_STAT, 32'h0);
         chk("ovr", {rd[3:2], rd[0]}, {k[0], 2'h3});
         apb(0, `ASU_ADDR_DATA, 32'h0);
         apb(0, `ASU_ADDR_STAT, 32'h0);
         chk("cleared", rd[5:0] & 6'h3d, 32'h0);
      end
      // Data interrupt disabled, then receiver off
      for (int k = 0; k < 2; k++) begin
         apb(1, `ASU_ADDR_CTL1, {31'h0, k == 0});
         apb(1, `ASU_ADDR_CTL0, k ? 32'h1 : 32'h3);
         i_rem.send({1'b0, 8'h5c}, 1'b1);
         wait_irq(0, 40);
         apb(0, `ASU_ADDR_STAT, 32'h0);
         chk("avail", rd[0], k == 0);
         apb(0, `ASU_ADDR_DATA, 32'h0);
      end
      // Multiprocessor: foreign address, then own address
      i_rem.nine_on = 1;
      apb(1, `ASU_ADDR_CTL0, 32'hb);
      apb(1, `ASU_ADDR_CTL1, 32'h5a02);
      for (int k = 0; k < 2; k++) begin
         i_rem.send(k ? 9'h15a : 9'h133, 1'b1);
         repeat (8) @(posedge pclk);
         apb(0, `ASU_ADDR_DATA, 32'h0);
         i_rem.send({1'b0, 8'h71}, 1'b1);
         wait_irq(k, 40);
         apb(0, `ASU_ADDR_DATA, 32'h0);
      end
      // Address bytes all interrupt; ninth bit sent from control
      apb(1, `ASU_ADDR_CTL1, 32'h5a0e);
      b = $urandom;
      apb(1, `ASU_ADDR_DATA, {24'h0, b});
      i_rem.send(9'h133, 1'b1);
      wait_irq(1, 40);
      apb(0, `ASU_ADDR_DATA, 32'h0);
      for (int i = 0; i < 100 && i_rem.got.size() == 0; i++) begin
         @(posedge pclk);
      end
      chk("mp_tx", i_rem.got.pop_front(), {3'b011, b});
      i_rem.nine_on = 0;
      apb(1, `ASU_ADDR_CTL1, 32'h0);
      // Clear-to-send gate
      apb(1, `ASU_ADDR_CTL0, 32'h7);
      b = $urandom;
      apb(1, `ASU_ADDR_DATA, {24'h0, b});
      repeat (100) @(posedge pclk);
      chk("gated", i_rem.got.size(), 0);
      cts_n <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(0, `ASU_ADDR_STAT, 32'h0);
      chk("reload", rd[6:1] & 6'h21, 32'h1);
      repeat (100) @(posedge pclk);
      chk("ungated", i_rem.got.pop_front(), exp_frame(b, 0));
      // Loopback, break, framing error
      apb(1, `ASU_ADDR_CTL0, 32'h83);
      b = $urandom;
      apb(1, `ASU_ADDR_DATA, {24'h0, b});
      wait_irq(1, 100);
      apb(0, `ASU_ADDR_DATA, 32'h0);
      chk("loop", rd, {24'h0, b});
      chk("quiet", i_rem.got.size(), 0);
      apb(1, `ASU_ADDR_CTL0, 32'h23);
      repeat (20) @(posedge pclk);
      chk("break", txd, 0);
      apb(1, `ASU_ADDR_CTL0, 32'h3);
      i_rem.send({1'b0, 8'h81}, 1'b0);
      wait_irq(1, 40);
      apb(0, `ASU_ADDR_STAT, 32'h0);
      chk("framing", rd[`ASU_S_FE], 1);
      end_sim();
   end
endmodule // test_async_serial_uart_core
